// ### src/irqrc_pkg.sv
// shared constants for the interrupt and reset-cause logic
package irqrc_pkg;
  localparam logic [10:0] VECTOR_ADDR     = 11'h008;
  localparam int          FLAG_TICK_BIT   = 0;
  localparam int          FLAG_CHG_BIT    = 1;
  localparam int          FLAG_EXT_BIT    = 2;
  localparam int          SR_PD_BIT       = 3;
  localparam int          SR_TO_BIT       = 4;
  localparam int          SR_RST_BIT      = 7;
  localparam logic [2:0]  FLAG_RESET      = 3'h0;
  localparam logic [2:0]  MASK_RESET      = 3'h0;
  localparam logic        RST_FLAG_POR    = 1'b0;
  localparam logic        TO_FLAG_POR     = 1'b1;
  localparam logic        PD_FLAG_POR     = 1'b1;
  localparam int          PORT_WIDTH      = 8;
  typedef enum logic [1:0] {
    IRQRC_RUN,
    IRQRC_SLEEP,
    IRQRC_ISR
  } irqrc_state_t;
endpackage

// ### src/irqrc_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module irqrc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // pins idle high; a low here would fake an edge after reset
      meta_q   <= '1;
      sync_out <= '1;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### src/irqrc_change_det.sv
// port input change detector; reference captured on a port read and on each detected change
`timescale 1ns/100ps
module irqrc_change_det #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_level,
  input  wire logic [WIDTH-1:0] pin_is_output,
  input  wire logic             bit0_is_ext_line,
  input  wire logic             port_read,
  output logic                  change_pulse
);
  logic [WIDTH-1:0] ref_q;
  logic [WIDTH-1:0] watch;

  always_comb begin
    watch    = ~pin_is_output;
    watch[0] = watch[0] & ~bit0_is_ext_line;
  end

  // a port read captures the reference level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_q <= '1;
    end else if (clk_en) begin
      ref_q <= (port_read || change_pulse) ? pin_level : ref_q;
    end
  end

  always_comb begin
    change_pulse = |((pin_level ^ ref_q) & watch);
  end
endmodule

// ### src/irqrc_top.sv
// interrupt request, vectoring, context save and reset-cause flags
`timescale 1ns/100ps
// Overview of operation
// - reset follows power-on, clear pin pulse, or watchdog expiry
// - power-on gives wake flag 0, expiry 1, power-down 1
// - clear pin keeps expiry/power-down; from sleep gives 0,1,0
// - watchdog clears wake and expiry, keeps power-down; from sleep all 0
// - pin-change wake gives wake flag 1, expiry 1, power-down 0
// - watchdog-clear sets expiry and power-down; sleep sets expiry, clears power-down
// - sources are tick overflow, port change, ext line, low voltage
// - each watched port pin change raises a request, outputs excluded
// - change wakes sleep; resumes in line or vectors to 008H
// - global enable set and cleared by its two instructions
// - enabled request with global enable fetches from 008H
// - flags except change flag set regardless of mask and enable
// - effective request is flags AND mask
// - return from service re-enables global interrupts
// - accumulator, status and bank select saved then restored
// - a new interrupt overwrites the single saved copy
// - flag register bits 2,1,0 are ext, change, tick; reset 0
// - mask register bits 2,1,0 are ext, change, tick; reset 0
// - status bit 7 wake flag, bit 4 expiry, bit 3 power-down
module irqrc_top
  import irqrc_pkg::*;
#(
  parameter int PW = PORT_WIDTH
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          power_on_evt,
  input  wire logic          clear_pin_n,
  input  wire logic          watchdog_expired,
  input  wire logic          tick_counter_ovf,
  input  wire logic [PW-1:0] port6_pins,
  input  wire logic [PW-1:0] port6_is_output,
  input  wire logic          port6_bit0_pin_is_ext,
  input  wire logic          port6_read,
  input  wire logic          low_voltage_evt,
  input  wire logic          low_voltage_enable,
  input  wire logic          watchdog_clear_instr,
  input  wire logic          sleep_instr,
  input  wire logic          global_irq_on_instr,
  input  wire logic          global_irq_off_instr,
  input  wire logic          return_from_isr_instr,
  input  wire logic          instr_boundary,
  input  wire logic          flag_wr,
  input  wire logic [2:0]    flag_wr_data,
  input  wire logic          mask_wr,
  input  wire logic [2:0]    mask_wr_data,
  input  wire logic [7:0]    accumulator,
  input  wire logic [7:0]    status_reg,
  input  wire logic [7:0]    bank_select_reg,
  output logic               core_reset,
  output logic               asleep,
  output logic               take_vector,
  output logic [10:0]        vector_addr,
  output logic               resume_inline,
  output logic               restore_ctx,
  output logic [7:0]         saved_accumulator,
  output logic [7:0]         saved_status_reg,
  output logic [7:0]         saved_bank_select_reg,
  output logic [2:0]         irq_flag_reg,
  output logic [2:0]         irq_mask_reg,
  output logic               low_voltage_flag,
  output logic               global_irq_en,
  output logic               reset_cause_rst,
  output logic               reset_cause_to,
  output logic               reset_cause_pd
);
  logic              clr_pin_s;
  logic              ext_s;
  logic [PW-1:0]     port_s;
  logic              clr_pin_q;
  logic              clr_seen_low_q;
  logic              ext_q;
  logic              clr_reset;
  logic              ext_fall;
  logic              chg_evt;
  logic [2:0]        effective;
  logic              lv_req;
  logic              any_req;
  logic              wake_chg;
  logic              wake_lv;
  logic              evt_rst;
  logic              vec_now;
  irqrc_state_t      state_q;
  irqrc_state_t      state_d;

  irqrc_sync #(
    .WIDTH(PW + 1)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({clear_pin_n, port6_pins}),
    .sync_out ({clr_pin_s, port_s})
  );

  assign ext_s = port_s[0];

  irqrc_change_det #(
    .WIDTH(PW)
  ) u_chg (
    .core_clk         (core_clk),
    .rst              (rst),
    .clk_en           (clk_en),
    .pin_level        (port_s),
    .pin_is_output    (port6_is_output),
    .bit0_is_ext_line (port6_bit0_pin_is_ext),
    .port_read        (port6_read),
    .change_pulse     (chg_evt)
  );

  // pin history for the two edge detectors; idle level is high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_pin_q <= 1'b1;
      ext_q     <= 1'b1;
    end else if (clk_en) begin
      clr_pin_q <= clr_pin_s;
      ext_q     <= ext_s;
    end
  end

  // clear pin: high-low-high completes a reset request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_seen_low_q <= 1'b0;
    end else if (clk_en) begin
      if (clr_reset) begin
        clr_seen_low_q <= 1'b0;
      end else if (clr_pin_q && !clr_pin_s) begin
        clr_seen_low_q <= 1'b1;
      end
    end
  end

  assign clr_reset = clr_seen_low_q && clr_pin_s;
  assign ext_fall  = port6_bit0_pin_is_ext && ext_q && !ext_s;
  // reset causes act only on enabled edges, like all other state
  assign evt_rst   = clk_en
                     && (power_on_evt || clr_reset || watchdog_expired);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else if (clk_en) begin
      core_reset <= power_on_evt | clr_reset | watchdog_expired;
    end
  end

  // flag register; hardware set wins over software clear
  always_ff @(posedge core_clk) begin
    if (rst || evt_rst) begin
      irq_flag_reg <= FLAG_RESET;
    end else if (clk_en) begin
      irq_flag_reg[FLAG_TICK_BIT] <=
        (flag_wr ? flag_wr_data[FLAG_TICK_BIT]
                 : irq_flag_reg[FLAG_TICK_BIT])
        | tick_counter_ovf;
      irq_flag_reg[FLAG_EXT_BIT] <=
        (flag_wr ? flag_wr_data[FLAG_EXT_BIT]
                 : irq_flag_reg[FLAG_EXT_BIT])
        | ext_fall;
      irq_flag_reg[FLAG_CHG_BIT] <=
        (flag_wr ? flag_wr_data[FLAG_CHG_BIT]
                 : irq_flag_reg[FLAG_CHG_BIT])
        | (chg_evt & irq_mask_reg[FLAG_CHG_BIT]);
    end
  end

  // low voltage keeps its own flag beside the three-bit register
  always_ff @(posedge core_clk) begin
    if (rst || evt_rst) begin
      low_voltage_flag <= 1'b0;
    end else if (clk_en) begin
      low_voltage_flag <= low_voltage_flag | low_voltage_evt;
    end
  end

  // mask register, written whole by the core
  always_ff @(posedge core_clk) begin
    if (rst || evt_rst) begin
      irq_mask_reg <= MASK_RESET;
    end else if (clk_en && mask_wr) begin
      irq_mask_reg <= mask_wr_data;
    end
  end

  assign effective = irq_flag_reg & irq_mask_reg;
  assign lv_req    = low_voltage_flag & low_voltage_enable;
  assign any_req   = (|effective) | lv_req;
  assign wake_chg  = chg_evt & irq_mask_reg[FLAG_CHG_BIT];
  assign wake_lv   = low_voltage_evt & low_voltage_enable;

  // global enable; taking a vector drops it until return or the enable instruction
  always_ff @(posedge core_clk) begin
    if (rst || evt_rst) begin
      global_irq_en <= 1'b0;
    end else if (clk_en) begin
      if (vec_now) begin
        global_irq_en <= 1'b0;
      end else if (global_irq_on_instr || return_from_isr_instr) begin
        global_irq_en <= 1'b1;
      end else if (global_irq_off_instr) begin
        global_irq_en <= 1'b0;
      end
    end
  end

  // vector decision; a sleep instruction finishes before any vector
  always_comb begin
    vec_now = 1'b0;
    if (!evt_rst && global_irq_en) begin
      if (state_q == IRQRC_SLEEP) begin
        vec_now = wake_chg || wake_lv;
      end else begin
        vec_now = instr_boundary && any_req && !sleep_instr;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      IRQRC_RUN: begin
        if (vec_now) begin
          state_d = IRQRC_ISR;
        end else if (sleep_instr) begin
          state_d = IRQRC_SLEEP;
        end
      end
      IRQRC_SLEEP: begin
        if (vec_now) begin
          state_d = IRQRC_ISR;
        end else if (wake_chg || wake_lv) begin
          state_d = IRQRC_RUN;
        end
      end
      IRQRC_ISR: begin
        if (vec_now) begin
          state_d = IRQRC_ISR;
        end else if (return_from_isr_instr) begin
          state_d = IRQRC_RUN;
        end else if (sleep_instr) begin
          state_d = IRQRC_SLEEP;
        end
      end
      default: state_d = IRQRC_RUN;
    endcase
  end

  // state register; any reset cause returns to run
  always_ff @(posedge core_clk) begin
    if (rst || evt_rst) begin
      state_q <= IRQRC_RUN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // vector and resume pulses toward the sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      take_vector   <= 1'b0;
      resume_inline <= 1'b0;
      restore_ctx   <= 1'b0;
      vector_addr   <= VECTOR_ADDR;
    end else if (clk_en) begin
      take_vector   <= vec_now;
      resume_inline <= (state_q == IRQRC_SLEEP) && !global_irq_en
                       && !evt_rst && (wake_chg || wake_lv);
      restore_ctx   <= (state_q == IRQRC_ISR) && return_from_isr_instr
                       && !vec_now;
      vector_addr   <= VECTOR_ADDR;
    end
  end

  // sleep state seen by the sequencer; any reset cause wakes the core
  always_ff @(posedge core_clk) begin
    if (rst) begin
      asleep <= 1'b0;
    end else if (clk_en) begin
      asleep <= (state_d == IRQRC_SLEEP) && !evt_rst;
    end
  end

  // single context copy; each new vector overwrites it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      saved_accumulator     <= 8'h00;
      saved_status_reg      <= 8'h00;
      saved_bank_select_reg <= 8'h00;
    end else if (clk_en && vec_now) begin
      saved_accumulator     <= accumulator;
      saved_status_reg      <= status_reg;
      saved_bank_select_reg <= bank_select_reg;
    end
  end

  // reset-cause flags: wake, expiry, power-down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_cause_rst <= RST_FLAG_POR;
      reset_cause_to  <= TO_FLAG_POR;
      reset_cause_pd  <= PD_FLAG_POR;
    end else if (clk_en) begin
      if (power_on_evt) begin
        reset_cause_rst <= RST_FLAG_POR;
        reset_cause_to  <= TO_FLAG_POR;
        reset_cause_pd  <= PD_FLAG_POR;
      end else if (watchdog_expired) begin
        reset_cause_rst <= 1'b0;
        reset_cause_to  <= 1'b0;
        if (state_q == IRQRC_SLEEP) begin
          reset_cause_pd <= 1'b0;
        end
      end else if (clr_reset) begin
        reset_cause_rst <= 1'b0;
        if (state_q == IRQRC_SLEEP) begin
          reset_cause_to <= 1'b1;
          reset_cause_pd <= 1'b0;
        end
      end else if (state_q == IRQRC_SLEEP && wake_chg) begin
        reset_cause_rst <= 1'b1;
        reset_cause_to  <= 1'b1;
        reset_cause_pd  <= 1'b0;
      end else if (watchdog_clear_instr) begin
        reset_cause_to <= 1'b1;
        reset_cause_pd <= 1'b1;
      end else if (sleep_instr && state_q != IRQRC_SLEEP) begin
        reset_cause_to <= 1'b1;
        reset_cause_pd <= 1'b0;
      end
    end
  end
endmodule

// ### tb/irqrc_core_model.sv
// core sequencer model: instruction boundaries and live context values
`timescale 1ns/100ps
module irqrc_core_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       bnd_on,
  input  wire logic [7:0] ctx_val,
  output logic            instr_boundary,
  output logic [7:0]      accumulator,
  output logic [7:0]      status_reg,
  output logic [7:0]      bank_select_reg
);
  logic ph_q;
  // two-cycle instructions, boundary marked on the second cycle
  always_ff @(posedge core_clk) begin
    ph_q <= rst ? 1'h0 : ~ph_q;
    instr_boundary <= !rst && bnd_on && ph_q;
  end
  // context follows ctx_val, so saved copies can be predicted
  always_ff @(posedge core_clk) begin
    accumulator <= ctx_val;
    status_reg <= {ctx_val[3:0], ctx_val[7:4]};
    bank_select_reg <= ~ctx_val;
  end
endmodule

// ### tb/irqrc_top_asserts.sv
// checker: timing and flag relations at the top-level ports
`timescale 1ns/100ps
module irqrc_top_asserts (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       power_on_evt,
  input wire logic       watchdog_expired,
  input wire logic       watchdog_clear_instr,
  input wire logic       sleep_instr,
  input wire logic       global_irq_on_instr,
  input wire logic       global_irq_off_instr,
  input wire logic       return_from_isr_instr,
  input wire logic       instr_boundary,
  input wire logic       low_voltage_enable,
  input wire logic       mask_wr,
  input wire logic [2:0] mask_wr_data,
  input wire logic       core_reset,
  input wire logic       asleep,
  input wire logic       take_vector,
  input wire logic       resume_inline,
  input wire logic       restore_ctx,
  input wire logic [2:0] irq_flag_reg,
  input wire logic [2:0] irq_mask_reg,
  input wire logic       low_voltage_flag,
  input wire logic       global_irq_en,
  input wire logic       reset_cause_rst,
  input wire logic       reset_cause_to,
  input wire logic       reset_cause_pd
);
  wire pend = |(irq_flag_reg & irq_mask_reg)
    || low_voltage_flag && low_voltage_enable;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);
  a_por_flags: assert property (
    power_on_evt |=> core_reset && !reset_cause_rst && reset_cause_to
      && reset_cause_pd) else $error("power-on cause flags wrong");
  a_wdt_run: assert property (
    watchdog_expired && !asleep && !power_on_evt && !watchdog_clear_instr
      && !sleep_instr |=> core_reset && !reset_cause_to
      && reset_cause_pd == $past(reset_cause_pd))
    else $error("watchdog cause flags wrong");
  a_sleep_flags: assert property (
    sleep_instr && !watchdog_clear_instr && !watchdog_expired
      && !power_on_evt |=> core_reset
      || asleep && reset_cause_to && !reset_cause_pd)
    else $error("sleep flags wrong");
  a_wdc_flags: assert property (
    watchdog_clear_instr && !sleep_instr && !watchdog_expired
      && !power_on_evt |=> core_reset || reset_cause_to && reset_cause_pd)
    else $error("watchdog-clear flags wrong");
  a_vec_gate: assert property (
    take_vector |-> !global_irq_en && $past(global_irq_en)
      && ($past(instr_boundary) || $past(asleep)))
    else $error("vector without enable or boundary");
  a_vec_cause: assert property (
    take_vector |-> $past(asleep) || $past(pend))
    else $error("vector without enabled request");
  a_return_from_isr_instr_gie: assert property (
    return_from_isr_instr && !global_irq_off_instr
      |=> global_irq_en || take_vector || core_reset)
    else $error("return did not enable interrupts");
  a_gie_off: assert property (
    global_irq_off_instr && !global_irq_on_instr && !return_from_isr_instr
      |=> !global_irq_en) else $error("disable instruction ignored");
  a_mask_write: assert property (
    mask_wr |=> core_reset || irq_mask_reg == $past(mask_wr_data))
    else $error("mask write lost");
  c_vector: cover property (take_vector);
  c_inline: cover property (resume_inline);
  c_restore: cover property (restore_ctx);
endmodule
bind irqrc_top irqrc_top_asserts chk_u (
  .core_clk, .rst, .clk_en, .power_on_evt, .watchdog_expired,
  .watchdog_clear_instr, .sleep_instr, .global_irq_on_instr,
  .global_irq_off_instr, .return_from_isr_instr, .instr_boundary,
  .low_voltage_enable, .mask_wr, .mask_wr_data, .core_reset, .asleep,
  .take_vector, .resume_inline, .restore_ctx, .irq_flag_reg,
  .irq_mask_reg, .low_voltage_flag, .global_irq_en, .reset_cause_rst,
  .reset_cause_to, .reset_cause_pd
);

// ### tb/irqrc_top_test.sv
// self-checking bench for the interrupt and reset-cause logic
`timescale 1ns/100ps
module irqrc_top_test
  import irqrc_pkg::*;
;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic        clk_en = 1'h1;
  logic        clear_pin_n = 1'h1;
  logic        port6_bit0_pin_is_ext = 1'h1;
  logic        low_voltage_enable = 1'h0;
  logic        port6_read = 1'h0;
  logic        flag_wr = 1'h0;
  logic        mask_wr = 1'h0;
  logic        bnd_on = 1'h0;
  logic [2:0]  flag_wr_data = 3'h0;
  logic [2:0]  mask_wr_data = 3'h0;
  logic [4:0]  ins = 5'h00;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  ctx_val = 8'h00;
  logic [7:0]  port6_pins = 8'hFF;
  logic [7:0]  port6_is_output = 8'h00;
  logic [7:0]  accumulator, status_reg, bank_select_reg;
  logic [7:0]  saved_accumulator, saved_status_reg, saved_bank_select_reg;
  logic [2:0]  irq_flag_reg, irq_mask_reg;
  logic [10:0] vector_addr;
  logic        instr_boundary, core_reset, asleep, take_vector;
  logic        resume_inline, restore_ctx, low_voltage_flag, global_irq_en;
  logic        reset_cause_rst, reset_cause_to, reset_cause_pd;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  wire  [3:0]  oo = {core_reset, restore_ctx, resume_inline, take_vector};
  irqrc_top dut_u (
    .core_clk, .rst, .clk_en, .clear_pin_n, .port6_pins, .port6_is_output,
    .port6_bit0_pin_is_ext, .port6_read, .low_voltage_enable, .flag_wr,
    .flag_wr_data, .mask_wr, .mask_wr_data, .accumulator, .status_reg,
    .bank_select_reg, .instr_boundary, .core_reset, .asleep, .take_vector,
    .vector_addr, .resume_inline, .restore_ctx, .saved_accumulator,
    .saved_status_reg, .saved_bank_select_reg, .irq_flag_reg,
    .irq_mask_reg, .low_voltage_flag, .global_irq_en, .reset_cause_rst,
    .reset_cause_to, .reset_cause_pd, .power_on_evt(ev[0]),
    .watchdog_expired(ev[1]), .tick_counter_ovf(ev[2]),
    .low_voltage_evt(ev[3]), .watchdog_clear_instr(ins[0]),
    .sleep_instr(ins[1]), .global_irq_on_instr(ins[2]),
    .global_irq_off_instr(ins[3]), .return_from_isr_instr(ins[4])
  );
  irqrc_core_model core_u (
    .core_clk, .rst, .bnd_on, .ctx_val, .instr_boundary, .accumulator,
    .status_reg, .bank_select_reg
  );
  always #5 core_clk = ~core_clk;
  task complete_run;
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      complete_run;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // step to falling edges, dropping every one-cycle strobe
  task nx(input int n);
    repeat (n) begin
      @(negedge core_clk);
      {ins, ev, port6_read, flag_wr, mask_wr} = '0;
    end
  endtask
  // watch one pulse output for a bounded number of cycles
  task wt(input int s, input logic want);
    logic h;
    h = 1'h0;
    for (int k = 0; k < 16 && !h; k++) begin
      @(posedge core_clk);
      #1 h = oo[s];
      nx(1);
    end
    chk(h, want);
  endtask
  task cause(input logic [2:0] e);
    nx(3);
    chk({reset_cause_rst, reset_cause_to, reset_cause_pd}, e);
  endtask
  task ctx(input logic [7:0] s);
    chk(vector_addr, VECTOR_ADDR);
    chk({saved_accumulator, saved_status_reg}, {s, s[3:0], s[7:4]});
    chk(saved_bank_select_reg, {8'h00, ~s});
  endtask
  task clr_pulse;
    clear_pin_n = 1'h0;
    nx(3);
    clear_pin_n = 1'h1;
    wt(3, 1'h1);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    nx(1);
    rst = 1'h0;
    chk({irq_flag_reg, irq_mask_reg, global_irq_en}, 16'h0);
    chk({reset_cause_rst, reset_cause_to, reset_cause_pd}, 16'h3);
    ev = 4'h4;
    nx(3);
    port6_pins[0] = 1'h0;
    ev = 4'h8;
    nx(6);
    chk({low_voltage_flag, irq_flag_reg}, 16'hD);
    port6_pins[0] = 1'h1;
    flag_wr = 1'h1;
    ctx_val = 8'h3C;
    nx(2);
    mask_wr = 1'h1;
    mask_wr_data = 3'h1;
    nx(1);
    chk({irq_flag_reg, irq_mask_reg}, 16'h1);
    ins = 5'h04;
    nx(2);
    chk(global_irq_en, 16'h1);
    ev = 4'h4;
    wt(0, 1'h0);
    bnd_on = 1'h1;
    wt(0, 1'h1);
    ctx(8'h3C);
    ctx_val = 8'hA5;
    nx(2);
    ins = 5'h04;
    wt(0, 1'h1);
    ctx(8'hA5);
    flag_wr = 1'h1;
    nx(1);
    ins = 5'h10;
    wt(2, 1'h1);
    chk(global_irq_en, 16'h1);
    wt(0, 1'h0);
    ins = 5'h08;
    nx(2);
    chk(global_irq_en, 16'h0);
    ev = 4'h2;
    wt(3, 1'h1);
    cause(3'h1);
    clr_pulse;
    cause(3'h1);
    ins = 5'h01;
    cause(3'h3);
    ins = 5'h02;
    cause(3'h2);
    chk(asleep, 16'h1);
    ev = 4'h2;
    wt(3, 1'h1);
    cause(3'h0);
    ins = 5'h02;
    nx(2);
    clr_pulse;
    cause(3'h2);
    ev = 4'h1;
    wt(3, 1'h1);
    cause(3'h3);
    port6_is_output = 8'h20;
    port6_read = 1'h1;
    nx(1);
    mask_wr = 1'h1;
    mask_wr_data = 3'h2;
    nx(1);
    ins = 5'h02;
    nx(2);
    port6_pins[5] = 1'h0;
    wt(1, 1'h0);
    port6_pins[3] = 1'h0;
    wt(1, 1'h1);
    cause(3'h6);
    chk({asleep, irq_flag_reg[1]}, 16'h1);
    flag_wr = 1'h1;
    nx(1);
    ins = 5'h04;
    nx(1);
    ins = 5'h02;
    nx(2);
    port6_pins[3] = 1'h1;
    wt(0, 1'h1);
    complete_run;
  end
endmodule
